// [hdl/hpm_defs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef HPM_DEFS_SVH
`define HPM_DEFS_SVH
`define HPM_ADDR_INT_MASK     7'h09
`define HPM_ADDR_PWM_SETUP    7'h0A
`define HPM_ADDR_SCRATCH      7'h0B
`define HPM_INT_MASK_RST      16'h0140
`define HPM_INT_MASK_KEEP     16'h01FF
`define HPM_PWM_SETUP_RST     16'h0000
`define HPM_SCRATCH_RST       16'h0000
`define HPM_BIT_SUPPLY        0
`define HPM_BIT_TEMP          1
`define HPM_BIT_BUS           2
`define HPM_BIT_RATE          14
`define HPM_DUTY_LSB          4
`define HPM_DUTY_MSB          13
`define HPM_SEL_MSB           2
`define HPM_CLK_HZ            40000000
`define HPM_STEPS             1024
`define HPM_BASE_RATE_HZ      200
`define HPM_TICK_DIV          (`HPM_CLK_HZ / (`HPM_BASE_RATE_HZ * `HPM_STEPS))
`endif

// [hdl/hpm_pkg.sv]
// types shared by the register bank and the pwm generator
package hpm_pkg;
    typedef logic [15:0] hpm_word_t;
    typedef logic [9:0]  hpm_duty_t;
    typedef enum logic [1:0] {
        HPM_RST_NONE    = 2'h0,
        HPM_RST_SOFT    = 2'h1,
        HPM_RST_RESTART = 2'h3
    } hpm_rst_kind_t;
endpackage

// [hdl/hpm_pwm_gen.sv]
// one internal pwm generator: 1024-step counter and duty compare
`timescale 1ns/10ps
module hpm_pwm_gen (
    // clock and reset
    input  wire logic            REF_CLK,
    input  wire logic            ARST_N,
    // step enables and setup
    input  wire logic            TICK_SLOW,
    input  wire logic            TICK_FAST,
    input  wire logic            RATE_SEL,
    input  wire hpm_pkg::hpm_duty_t DUTY,
    // drive output
    output logic                 PWM_OUT
);
    import hpm_pkg::*;

    typedef struct packed {
        logic [9:0] cnt;
        logic       out;
    } hpm_gen_st_t;

    hpm_gen_st_t st_q;
    hpm_gen_st_t st_d;
    logic        step;

    // the rate picks which divided enable advances the counter
    assign step = RATE_SEL ? TICK_FAST : TICK_SLOW;

    // free-running count; output high while count below duty, all ones forced on
    always_comb begin
        st_d = st_q;
        if (step) begin
            st_d.cnt = st_q.cnt + 10'h001;
            st_d.out = (DUTY == 10'h3FF) || (st_q.cnt < DUTY);
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign PWM_OUT = st_q.out;

    // zero duty turns the switch off from the next counter step on
    zero_off_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (DUTY == 10'h000) && step |=> !PWM_OUT)
        else $error("pwm on with zero duty");
endmodule

// [hdl/hpm_regs.sv]
// register bank: interrupt mask, pwm setup for four generators, scratch word
//
// Behaviour
// - bus mask bit 2 set: one interrupt pulse per bus flag set event.
// - thermal mask bit 1 set: one interrupt pulse per thermal flag set event.
// - supply mask bit 0 set: one interrupt pulse per supply flag set event.
// - mask resets to 0x0140; restart clears bits 15:9, keeps 8:0.
// - rate bit 14 selects 100 Hz (0) or 200 Hz (1) period.
// - duty bits 13:4 give on-time value/1024; zero off, all ones on.
// - select bits 2:0 address generators 0..3; codes 1xx are ignored.
// - bits 15 and 3 of pwm setup read zero, writes ignored.
// - pwm setup clears on reset; restart clears 15 and 3:0 only.
// - the four generators only drive the high-side switches.
// - output correct only after one full pwm pulse after setup.
// - generator timing derives from the internal clock.
// - scratch word is host read/write only; device never changes it.
// - scratch clears on power-on and soft reset, kept through restart.
// - scratch accessible only while the device is in normal mode.
// - enabled event pulses interrupt even if flag was already set.
// - switch code 0100..0111 routes generator one..four to the switch.
`timescale 1ns/10ps
`include "hpm_defs.svh"
module hpm_regs (
    // clock and reset
    input  wire logic                  REF_CLK,
    input  wire logic                  ARST_N,
    // device reset requests, same clock domain
    input  wire hpm_pkg::hpm_rst_kind_t RST_KIND,
    input  wire logic                  NORMAL_MODE,
    // register access port
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    input  wire logic [6:0]            REG_ADDR,
    input  wire hpm_pkg::hpm_word_t    REG_WDATA,
    output hpm_pkg::hpm_word_t         REG_RDATA,
    output logic                       REG_RVALID,
    // status flag set events, same clock domain, one-cycle pulses
    input  wire logic                  EVT_BUS,
    input  wire logic                  EVT_TEMP,
    input  wire logic                  EVT_SUPPLY,
    // interrupt output, low for one cycle after each enabled event
    output logic                       INTERRUPT_OUT_N,
    // high-side switch routing codes and drive
    input  wire logic [3:0]            HS_CFG_0,
    input  wire logic [3:0]            HS_CFG_1,
    input  wire logic [3:0]            HS_CFG_2,
    output logic [2:0]                 HS_PWM_DRIVE
);
    import hpm_pkg::*;

    typedef struct packed {
        hpm_word_t  mask;
        logic [1:0] sel;
        logic [3:0] rate;
        hpm_duty_t [3:0] duty;
        hpm_word_t  scratch;
        hpm_word_t  rdata;
        logic       rvalid;
        logic       irq_n;
        logic [7:0] div_cnt;
        logic       half;
        logic       tick_fast;
        logic       tick_slow;
        logic [2:0] hs_drv;
    } hpm_reg_st_t;

    // the step divider needs eight bits; six would silently wrap the count
    localparam logic [7:0] DIV_LAST = 8'(`HPM_TICK_DIV - 1);

    hpm_reg_st_t st_q;
    hpm_reg_st_t st_d;
    logic [3:0]  gen_out;
    logic        wr_pwm;
    logic        irq_evt;
    logic [3:0]  hs_cfg [3];

    assign hs_cfg[0] = HS_CFG_0;
    assign hs_cfg[1] = HS_CFG_1;
    assign hs_cfg[2] = HS_CFG_2;

    // select codes 1xx address nothing, so such a write stores nothing
    assign wr_pwm = REG_WR && (REG_ADDR == `HPM_ADDR_PWM_SETUP) && !REG_WDATA[`HPM_SEL_MSB];

    // each masked event is its own trigger, so an already set flag still pulses
    assign irq_evt = (EVT_BUS    && st_q.mask[`HPM_BIT_BUS])
                  || (EVT_TEMP   && st_q.mask[`HPM_BIT_TEMP])
                  || (EVT_SUPPLY && st_q.mask[`HPM_BIT_SUPPLY]);

    // next state: resets by type, register writes, reads, divider, routing
    always_comb begin
        st_d           = st_q;
        st_d.rvalid    = 1'b0;
        st_d.irq_n     = !irq_evt;
        st_d.tick_fast = 1'b0;
        st_d.tick_slow = 1'b0;
        // one divider from the reference clock feeds all generators
        if (st_q.div_cnt == DIV_LAST) begin
            st_d.div_cnt   = 8'h00;
            st_d.half      = !st_q.half;
            st_d.tick_fast = 1'b1;
            st_d.tick_slow = st_q.half;
        end else begin
            st_d.div_cnt = st_q.div_cnt + 8'h01;
        end
        // routing codes 0100..0111 pick a generator; others leave the pwm drive low
        for (int i = 0; i < 3; i++) begin
            st_d.hs_drv[i] = (hs_cfg[i][3:2] == 2'b01) && gen_out[hs_cfg[i][1:0]];
        end
        if (REG_WR) begin
            unique case (REG_ADDR)
                `HPM_ADDR_INT_MASK: begin
                    st_d.mask = REG_WDATA & `HPM_INT_MASK_KEEP;
                end
                `HPM_ADDR_PWM_SETUP: begin
                    if (wr_pwm) begin
                        st_d.sel                     = REG_WDATA[1:0];
                        st_d.rate[REG_WDATA[1:0]]    = REG_WDATA[`HPM_BIT_RATE];
                        st_d.duty[REG_WDATA[1:0]]    = REG_WDATA[`HPM_DUTY_MSB:`HPM_DUTY_LSB];
                    end
                end
                `HPM_ADDR_SCRATCH: begin
                    if (NORMAL_MODE) begin
                        st_d.scratch = REG_WDATA;
                    end
                end
                default: begin
                end
            endcase
        end
        if (REG_RD) begin
            st_d.rvalid = 1'b1;
            unique case (REG_ADDR)
                `HPM_ADDR_INT_MASK:  st_d.rdata = st_q.mask;
                // reserved bits 15 and 3 are wired to zero
                `HPM_ADDR_PWM_SETUP: st_d.rdata = {1'b0, st_q.rate[st_q.sel], st_q.duty[st_q.sel],
                                                   1'b0, 1'b0, st_q.sel};
                `HPM_ADDR_SCRATCH:   st_d.rdata = NORMAL_MODE ? st_q.scratch : 16'h0000;
                default:             st_d.rdata = 16'h0000;
            endcase
        end
        // reset types override same-cycle writes to the fields they reset; reads and other writes still go through
        unique case (RST_KIND)
            HPM_RST_SOFT: begin
                st_d.mask    = `HPM_INT_MASK_RST;
                st_d.sel     = 2'h0;
                st_d.rate    = 4'h0;
                st_d.duty    = '0;
                st_d.scratch = `HPM_SCRATCH_RST;
            end
            HPM_RST_RESTART: begin
                st_d.mask = st_q.mask & `HPM_INT_MASK_KEEP;
                st_d.sel  = 2'h0;
            end
            default: begin
            end
        endcase
    end

    // single state register; asynchronous reset acts as power-on
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q       <= '0;
            st_q.mask  <= `HPM_INT_MASK_RST;
            st_q.irq_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // four generators, each with its own stored rate and duty
    for (genvar g = 0; g < 4; g++) begin : gen_pwm
        hpm_pwm_gen u_gen (
            .REF_CLK   (REF_CLK),
            .ARST_N    (ARST_N),
            .TICK_SLOW (st_q.tick_slow),
            .TICK_FAST (st_q.tick_fast),
            .RATE_SEL  (st_q.rate[g]),
            .DUTY      (st_q.duty[g]),
            .PWM_OUT   (gen_out[g])
        );
    end

    assign REG_RDATA       = st_q.rdata;
    assign REG_RVALID      = st_q.rvalid;
    assign INTERRUPT_OUT_N = st_q.irq_n;
    assign HS_PWM_DRIVE    = st_q.hs_drv;

    // a masked bus event pulses the interrupt next cycle
    bus_irq_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        EVT_BUS && st_q.mask[`HPM_BIT_BUS] |=> !INTERRUPT_OUT_N)
        else $error("bus event lost");
    temp_irq_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        EVT_TEMP && st_q.mask[`HPM_BIT_TEMP] |=> !INTERRUPT_OUT_N)
        else $error("thermal event lost");
    supply_irq_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        EVT_SUPPLY && st_q.mask[`HPM_BIT_SUPPLY] |=> !INTERRUPT_OUT_N)
        else $error("supply event lost");
    no_spurious_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        !irq_evt |=> INTERRUPT_OUT_N)
        else $error("interrupt without enabled event");
    restart_mask_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        RST_KIND == HPM_RST_RESTART |=> st_q.mask == ($past(st_q.mask) & `HPM_INT_MASK_KEEP))
        else $error("restart mask wrong");
    soft_rst_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        RST_KIND == HPM_RST_SOFT |=> st_q.mask == `HPM_INT_MASK_RST && st_q.scratch == 16'h0000)
        else $error("soft reset values wrong");
    pwm_rsvd_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        $past(REG_RD) && $past(REG_ADDR) == `HPM_ADDR_PWM_SETUP |-> !REG_RDATA[15] && !REG_RDATA[3])
        else $error("reserved pwm bit reads one");
    scratch_keep_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        !(REG_WR && NORMAL_MODE && REG_ADDR == `HPM_ADDR_SCRATCH) && RST_KIND != HPM_RST_SOFT
        |=> $stable(st_q.scratch))
        else $error("scratch changed by device");
    restart_pwm_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        RST_KIND == HPM_RST_RESTART |=> st_q.sel == 2'h0 && $stable(st_q.duty))
        else $error("restart pwm setup wrong");
endmodule

// [dv/hpm_host_model.sv]
// host controller model: register strobes launched from the falling edge
`timescale 1ns/10ps
module hpm_host_model (
    // clock
    input  wire logic               REF_CLK,
    // register access
    output logic                    REG_WR,
    output logic                    REG_RD,
    output logic [6:0]              REG_ADDR,
    output hpm_pkg::hpm_word_t      REG_WDATA,
    input  wire hpm_pkg::hpm_word_t REG_RDATA,
    input  wire logic               REG_RVALID
);
    import hpm_pkg::*;
    // idle strobes low at time zero
    initial begin
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_ADDR = 7'h7F;
        REG_WDATA = 16'hFFFF;
    end
    // hold for one rising edge, then show the inverse so stale data never passes
    task automatic wr(input logic [6:0] a, input hpm_word_t d);
        @(negedge REF_CLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(negedge REF_CLK);
        REG_WR = 1'b0;
        REG_ADDR = ~a;
        REG_WDATA = ~d;
    endtask
    // answer is awaited a bounded number of cycles
    task automatic rd(input logic [6:0] a, output hpm_word_t d, output logic ok);
        @(negedge REF_CLK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge REF_CLK);
        REG_RD = 1'b0;
        REG_ADDR = ~a;
        for (int i = 0; i < 4 && REG_RVALID !== 1'b1; i++) begin
            @(negedge REF_CLK);
        end
        ok = REG_RVALID;
        d = REG_RDATA;
    endtask
endmodule

// [dv/test_hs_pwm_and_int_mask_regs.sv]
// testbench: register bank reset kinds, interrupt mask, pwm setup, scratch word
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module test_hs_pwm_and_int_mask_regs;
    import hpm_pkg::*;
    logic          ref_clk = 1'b0;
    logic          arst_n = 1'b0;
    hpm_rst_kind_t rst_kind = HPM_RST_NONE;
    logic          normal_mode = 1'b1;
    logic          reg_wr, reg_rd, reg_rvalid, int_n;
    logic [6:0]    reg_addr;
    hpm_word_t     wdata, rdata;
    logic [2:0]    evt = 3'h0;
    logic [3:0]    hs_cfg_0 = 4'h0, hs_cfg_1 = 4'h0, hs_cfg_2 = 4'h0;
    logic [2:0]    drive;
    int            error_cnt = 0;
    int            tests_run = 0;
    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;
    hpm_host_model u_host (.REF_CLK(ref_clk), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(reg_rvalid));
    hpm_regs uut (.REF_CLK(ref_clk), .ARST_N(arst_n), .RST_KIND(rst_kind), .NORMAL_MODE(normal_mode),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .REG_RVALID(reg_rvalid), .EVT_BUS(evt[2]), .EVT_TEMP(evt[1]), .EVT_SUPPLY(evt[0]),
        .INTERRUPT_OUT_N(int_n), .HS_CFG_0(hs_cfg_0), .HS_CFG_1(hs_cfg_1), .HS_CFG_2(hs_cfg_2),
        .HS_PWM_DRIVE(drive));
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // read and compare; a missing answer ends the run
    task automatic rchk(input logic [6:0] a, input hpm_word_t e);
        hpm_word_t d;
        logic      ok;
        u_host.rd(a, d, ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            results();
        end
        `CHK("rdata", e, d)
    endtask
    // one-cycle event; interrupt low exactly one cycle when enabled
    task automatic ev(input int k, input logic on);
        @(negedge ref_clk);
        evt[k] = 1'b1;
        @(negedge ref_clk);
        evt = 3'h0;
        `CHK("int_n", ~on, int_n)
        @(negedge ref_clk);
        `CHK("int_n idle", 1'b1, int_n)
    endtask
    // one device reset request of the given kind
    task automatic dev_rst(input hpm_rst_kind_t k);
        @(negedge ref_clk);
        rst_kind = k;
        @(negedge ref_clk);
        rst_kind = HPM_RST_NONE;
    endtask
    initial begin
        repeat (16) @(negedge ref_clk);
        arst_n = 1'b1;
        rchk(7'h09, 16'h0140);
        rchk(7'h0A, 16'h0000);
        rchk(7'h0B, 16'h0000);
        rchk(7'h20, 16'h0000);
        ev(2, 1'b0);
        u_host.wr(7'h09, 16'hFFFF);
        rchk(7'h09, 16'h01FF);
        ev(2, 1'b1);
        ev(1, 1'b1);
        ev(0, 1'b1);
        ev(0, 1'b1);
        u_host.wr(7'h09, 16'h0000);
        ev(1, 1'b0);
        ev(0, 1'b0);
        // duties are set before any switch is routed to a generator
        u_host.wr(7'h0A, 16'h7FF0);
        u_host.wr(7'h0A, 16'h0001);
        u_host.wr(7'h0A, 16'hFFFB);
        rchk(7'h0A, 16'h7FF3);
        u_host.wr(7'h0A, 16'h0004);
        rchk(7'h0A, 16'h7FF3);
        hs_cfg_0 = 4'h4;
        hs_cfg_1 = 4'h5;
        hs_cfg_2 = 4'h7;
        // outputs follow a new duty only at a counter step, 195 or 390 cycles apart
        repeat (400) @(negedge ref_clk);
        `CHK("drive", 3'b101, drive)
        `CHK("drive", 3'b101, drive)
        // scratch is host-owned and gated by normal mode
        u_host.wr(7'h0B, 16'hA5C3);
        rchk(7'h0B, 16'hA5C3);
        normal_mode = 1'b0;
        u_host.wr(7'h0B, 16'h1234);
        rchk(7'h0B, 16'h0000);
        normal_mode = 1'b1;
        rchk(7'h0B, 16'hA5C3);
        u_host.wr(7'h09, 16'h0147);
        dev_rst(HPM_RST_RESTART);
        rchk(7'h09, 16'h0147);
        rchk(7'h0A, 16'h7FF0);
        rchk(7'h0B, 16'hA5C3);
        dev_rst(HPM_RST_SOFT);
        rchk(7'h09, 16'h0140);
        rchk(7'h0A, 16'h0000);
        rchk(7'h0B, 16'h0000);
        repeat (400) @(negedge ref_clk);
        `CHK("drive", 3'b000, drive)
        results();
    end
endmodule
